/* File: logic/long_mul_div_saturate_pkg.sv */
/*
 * long_mul_div_saturate_pkg: types and constants of the datapath.
 * assumes: imported by the datapath and its request source.
 */
package long_mul_div_saturate_pkg;

    // datapath widths
    localparam int unsigned WORD_W      = 32;               // operand and result word
    localparam int unsigned HALF_W      = 16;               // packed halfword lane
    localparam int unsigned BYTE_W      = 8;                // packed byte lane
    localparam int unsigned SAT_N_W     = 6;                // saturation width field
    localparam int unsigned SHIFT_W     = 5;                // pre-saturation shift amount

    // lane saturation widths as fed to the saturation functions
    localparam logic [5:0]  SAT_N_WORD  = 6'h20;            // 32-bit signed lane
    localparam logic [5:0]  SAT_N_HALF  = 6'h10;            // 16-bit signed lane
    localparam logic [5:0]  SAT_N_BYTE  = 6'h08;            // 8-bit signed lane

    // legal saturation width limits
    localparam logic [5:0]  SIGNED_SATURATE_N_MIN  = 6'h01;            // signed word, least n
    localparam logic [5:0]  SIGNED_SATURATE_N_MAX  = 6'h20;            // signed word, largest n
    localparam logic [5:0]  UNSIGNED_SATURATE_N_MAX  = 6'h1F;            // unsigned word, largest n
    localparam logic [5:0]  SIGNED_SATURATE_HALFWORDS_N_MAX = 6'h10;           // signed halfword, largest n
    localparam logic [5:0]  UNSIGNED_SATURATE_HALFWORDS_N_MAX = 6'h0F;           // unsigned halfword, largest n

    // reset values
    localparam logic [31:0] RESULT_RESET   = 32'h0000_0000; // result words after reset
    localparam logic        SAT_FLAG_RESET = 1'b0;          // sticky saturation flag
    localparam logic [31:0] DIV_ZERO_RESULT = 32'h0000_0000; // quotient for zero divisor

    // timing: a taken request answers this many enabled edges later
    localparam int unsigned RESULT_LATENCY = 1;

    // operation codes
    typedef enum logic [4:0] {
        UNSIGNED_LONG_MULTIPLY,
        UNSIGNED_LONG_MULTIPLY_ACCUMULATE,
        SIGNED_LONG_MULTIPLY,
        SIGNED_LONG_MULTIPLY_ACCUMULATE,
        SIGNED_DIVIDE,
        UNSIGNED_DIVIDE,
        SIGNED_SATURATE,
        UNSIGNED_SATURATE,
        SIGNED_SATURATE_HALFWORDS,
        UNSIGNED_SATURATE_HALFWORDS,
        SATURATING_ADD,
        SATURATING_SUBTRACT,
        SATURATING_ADD_BYTES,
        SATURATING_ADD_HALFWORDS,
        SATURATING_SUBTRACT_BYTES,
        SATURATING_SUBTRACT_HALFWORDS,
        SATURATING_ADD_SUBTRACT_EXCHANGE,
        SATURATING_SUBTRACT_ADD_EXCHANGE
    } op_t;

    // one issued operation with its operands
    typedef struct packed {
        logic        valid;           // request present this cycle
        op_t         op;              // operation to perform
        logic        cond_pass;       // condition code evaluated true
        logic [31:0] first_operand;   // multiplicand, dividend, addend
        logic [31:0] second_operand;  // multiplier, divisor, value to saturate
        logic [31:0] acc_high;        // current result_high_word, accumulate only
        logic [31:0] acc_low;         // current result_low_word, accumulate only
        logic [5:0]  sat_width;       // saturation width n
        logic        shift_right;     // 1: arithmetic_shift_right, 0: logical_shift_left
        logic [4:0]  shift_amount;    // pre-saturation shift distance
    } req_t;

endpackage : long_mul_div_saturate_pkg

/* File: logic/long_mul_div_saturate_unit.sv */
/*
 * long_mul_div_saturate_unit: one-cycle multiply, divide, saturate datapath
 * with the sticky saturation flag.
 * assumes: decode on CLK_I gives the condition result; status writes are
 * one-cycle strobes; the register file obeys the write strobes.
 */
`timescale 1ns/1ps

// Overview of operation
// - long multiply splits product into low, high
// - unsigned accumulate adds product to high:low pair
// - signed accumulate adds signed product to pair
// - these operations never touch condition flags
// - divide signed or unsigned, truncating toward zero
// - divide changes no status flag
// - unsigned saturation clamps to zero and 2^n-1
// - a saturate or 32-bit saturating add/sub clamp sets the sticky flag
// - only status write clears; flag read via status
// - signed saturate shifts, then clamps signed range
// - unsigned saturate shifts, then clamps unsigned range
// - width n: 1..32 signed, 0..31 unsigned
// - shift is right arithmetic 1..31, left 0..31
// - halfword saturate clamps both halves independently
// - saturating add/sub clamps to lane signed range
// - packed forms work on independent byte/halfword lanes
// - packed add/sub never touch the sticky flag
// - add-subtract exchange crosses halves, clamps 16 bits
module long_mul_div_saturate_unit
(
    // clock, reset, enable
    input  wire logic                                 CLK_I,
    input  wire logic                                 NRST_I,
    input  wire logic                                 CE_I,
    // operation request from decode
    input  wire long_mul_div_saturate_pkg::req_t      REQ_I,
    // status word access
    input  wire logic                                 STATUS_WR_I,
    input  wire logic                                 STATUS_WR_SAT_I,
    input  wire logic                                 DIV_TRAP_EN_I,
    // results towards the register file
    output logic                                      RES_VALID_O,
    output logic                                      WR_LOW_O,
    output logic                                      WR_HIGH_O,
    output logic [31:0]                               RES_LOW_O,
    output logic [31:0]                               RES_HIGH_O,
    // status and faults
    output logic                                      SAT_FLAG_O,
    output logic                                      DIV_FAULT_O
);
    import long_mul_div_saturate_pkg::*;

    // signed clamp of v to n bits, n in 1..32; returns {clamped, value}
    function automatic logic [32:0] sat_signed(input logic signed [63:0] v,
                                               input logic [5:0] n);
        logic signed [63:0] hi;
        logic signed [63:0] lo;
        logic signed [63:0] r;
        hi = $signed((64'h1 << (n - 6'h01)) - 64'h1);
        lo = -hi - 64'sh1;
        if (v > hi) begin                       // above top of range
            r = hi;
        end else if (v < lo) begin              // below bottom of range
            r = lo;
        end else begin                          // already in range
            r = v;
        end
        return {(r != v), r[31:0]};
    endfunction : sat_signed

    // unsigned clamp of signed v to n bits, n in 0..31; returns {clamped, value}
    function automatic logic [32:0] sat_unsigned(input logic signed [63:0] v,
                                                 input logic [5:0] n);
        logic signed [63:0] hi;
        logic signed [63:0] r;
        hi = $signed((64'h1 << n) - 64'h1);
        if (v < 64'sh0) begin                   // negative input goes to zero
            r = 64'sh0;
        end else if (v > hi) begin              // too large goes to 2^n-1
            r = hi;
        end else begin
            r = v;
        end
        return {(r != v), r[31:0]};
    endfunction : sat_unsigned

    // bound a requested width into [lo, hi] so an illegal field cannot shift wild
    function automatic logic [5:0] bound_n(input logic [5:0] n, input logic [5:0] lo,
                                           input logic [5:0] hi);
        return (n < lo) ? lo : ((n > hi) ? hi : n);
    endfunction : bound_n

    // 16-bit signed saturating add or subtract of two halfwords
    function automatic logic [15:0] sat_half(input logic signed [15:0] a,
                                             input logic signed [15:0] b, input logic sub);
        logic signed [63:0] s;
        logic [32:0]        r;
        s = sub ? a - b : a + b;
        r = sat_signed(s, SAT_N_HALF);
        return r[15:0];
    endfunction : sat_half

    // 8-bit signed saturating add or subtract of two bytes
    function automatic logic [7:0] sat_byte(input logic signed [7:0] a,
                                            input logic signed [7:0] b, input logic sub);
        logic signed [63:0] s;
        logic [32:0]        r;
        s = sub ? a - b : a + b;
        r = sat_signed(s, SAT_N_BYTE);
        return r[7:0];
    endfunction : sat_byte

    // combinational results of the current request
    logic [31:0] low_d;                 // next low result word
    logic [31:0] high_d;                // next high result word
    logic        wr_low_d;              // low word is to be written
    logic        wr_high_d;             // high word is to be written
    logic        sat_hit;               // a saturate or 32-bit saturating add/sub clamped a value
    logic        div_fault_d;           // zero divisor with trap enabled

    // registered outputs
    logic        res_valid_q;
    logic        wr_low_q;
    logic        wr_high_q;
    logic [31:0] res_low_q;
    logic [31:0] res_high_q;
    logic        sat_flag_q;
    logic        div_fault_q;

    // shared operand views
    logic signed [63:0] prod_s;         // signed 64-bit product
    logic [63:0]        prod_u;         // unsigned 64-bit product
    logic [63:0]        acc;            // accumulating pair high:low
    logic [63:0]        mul_sum;        // product, plus accumulator for accumulate ops
    logic [31:0]        shifted;        // value to saturate after its shift
    logic [31:0]        mag_n;          // dividend magnitude
    logic [31:0]        mag_d;          // divisor magnitude
    logic [31:0]        mag_q;          // quotient magnitude
    logic [32:0]        sat_r;          // {clamped, value} of word saturation
    logic [32:0]        sat_lo;         // bottom halfword saturation
    logic [32:0]        sat_hi;         // top halfword saturation
    logic [5:0]         n_eff;          // bounded saturation width

    // products and accumulate, all modulo 2^64
    assign prod_s  = 64'($signed(REQ_I.first_operand)) * 64'($signed(REQ_I.second_operand));
    assign prod_u  = {32'h0, REQ_I.first_operand} * {32'h0, REQ_I.second_operand};
    assign acc     = {REQ_I.acc_high, REQ_I.acc_low};

    // pre-saturation shift of the value to saturate
    assign shifted = REQ_I.shift_right
                   ? 32'($signed(REQ_I.second_operand) >>> REQ_I.shift_amount)
                   : (REQ_I.second_operand << REQ_I.shift_amount);

    // divide works on magnitudes so the quotient truncates toward zero
    assign mag_n = (REQ_I.op == SIGNED_DIVIDE && REQ_I.first_operand[31])
                 ? (32'h0 - REQ_I.first_operand) : REQ_I.first_operand;
    assign mag_d = (REQ_I.op == SIGNED_DIVIDE && REQ_I.second_operand[31])
                 ? (32'h0 - REQ_I.second_operand) : REQ_I.second_operand;
    assign mag_q = (mag_d == 32'h0) ? 32'h0 : (mag_n / mag_d);

    // operation select: compute result words, write strobes and clamp event
    always_comb begin
        mul_sum     = 64'h0;
        sat_r       = 33'h0;
        sat_lo      = 33'h0;
        sat_hi      = 33'h0;
        n_eff       = 6'h0;
        low_d       = RESULT_RESET;
        high_d      = RESULT_RESET;
        wr_low_d    = 1'b1;
        wr_high_d   = 1'b0;
        sat_hit     = 1'b0;
        div_fault_d = 1'b0;
        unique case (REQ_I.op)
            // plain long multiply writes both halves
            UNSIGNED_LONG_MULTIPLY, SIGNED_LONG_MULTIPLY: begin
                mul_sum   = (REQ_I.op == SIGNED_LONG_MULTIPLY) ? prod_s : prod_u;
                low_d     = mul_sum[31:0];
                high_d    = mul_sum[63:32];
                wr_high_d = 1'b1;
            end
            // unsigned accumulate into the destination pair
            UNSIGNED_LONG_MULTIPLY_ACCUMULATE: begin
                mul_sum   = prod_u + acc;
                low_d     = mul_sum[31:0];
                high_d    = mul_sum[63:32];
                wr_high_d = 1'b1;
            end
            // signed accumulate; two's complement sum is the same bits
            SIGNED_LONG_MULTIPLY_ACCUMULATE: begin
                mul_sum   = prod_s + acc;
                low_d     = mul_sum[31:0];
                high_d    = mul_sum[63:32];
                wr_high_d = 1'b1;
            end
            // divides, with zero-divisor handling and no flag change
            SIGNED_DIVIDE, UNSIGNED_DIVIDE: begin
                if (REQ_I.second_operand == 32'h0) begin
                    low_d       = DIV_ZERO_RESULT;
                    wr_low_d    = !DIV_TRAP_EN_I;
                    div_fault_d = DIV_TRAP_EN_I;
                end else if (REQ_I.op == SIGNED_DIVIDE &&
                             (REQ_I.first_operand[31] ^ REQ_I.second_operand[31])) begin
                    low_d = 32'h0 - mag_q;
                end else begin
                    low_d = mag_q;
                end
            end
            // word saturation after the optional shift
            SIGNED_SATURATE: begin
                n_eff   = bound_n(REQ_I.sat_width, SIGNED_SATURATE_N_MIN, SIGNED_SATURATE_N_MAX);
                sat_r   = sat_signed(64'($signed(shifted)), n_eff);
                low_d   = sat_r[31:0];
                sat_hit = sat_r[32];
            end
            UNSIGNED_SATURATE: begin
                n_eff   = bound_n(REQ_I.sat_width, 6'h00, UNSIGNED_SATURATE_N_MAX);
                sat_r   = sat_unsigned(64'($signed(shifted)), n_eff);
                low_d   = sat_r[31:0];
                sat_hit = sat_r[32];
            end
            // two independent halfword saturations, no shift
            SIGNED_SATURATE_HALFWORDS: begin
                n_eff   = bound_n(REQ_I.sat_width, SIGNED_SATURATE_N_MIN, SIGNED_SATURATE_HALFWORDS_N_MAX);
                sat_lo  = sat_signed(64'($signed(REQ_I.second_operand[15:0])), n_eff);
                sat_hi  = sat_signed(64'($signed(REQ_I.second_operand[31:16])), n_eff);
                low_d   = {sat_hi[15:0], sat_lo[15:0]};
                sat_hit = sat_lo[32] | sat_hi[32];
            end
            UNSIGNED_SATURATE_HALFWORDS: begin
                n_eff   = bound_n(REQ_I.sat_width, 6'h00, UNSIGNED_SATURATE_HALFWORDS_N_MAX);
                sat_lo  = sat_unsigned(64'($signed(REQ_I.second_operand[15:0])), n_eff);
                sat_hi  = sat_unsigned(64'($signed(REQ_I.second_operand[31:16])), n_eff);
                low_d   = {sat_hi[15:0], sat_lo[15:0]};
                sat_hit = sat_lo[32] | sat_hi[32];
            end
            // 32-bit saturating add and subtract set the sticky flag on clamp
            SATURATING_ADD: begin
                sat_r   = sat_signed(64'($signed(REQ_I.first_operand))
                         + 64'($signed(REQ_I.second_operand)), SAT_N_WORD);
                low_d   = sat_r[31:0];
                sat_hit = sat_r[32];
            end
            SATURATING_SUBTRACT: begin
                sat_r   = sat_signed(64'($signed(REQ_I.first_operand))
                         - 64'($signed(REQ_I.second_operand)), SAT_N_WORD);
                low_d   = sat_r[31:0];
                sat_hit = sat_r[32];
            end
            // packed lanes: clamp per lane, sticky flag left alone
            SATURATING_ADD_BYTES, SATURATING_SUBTRACT_BYTES: begin
                for (int i = 0; i < 4; i++) begin
                    low_d[i*8 +: 8] = sat_byte(REQ_I.first_operand[i*8 +: 8],
                                               REQ_I.second_operand[i*8 +: 8],
                                               REQ_I.op == SATURATING_SUBTRACT_BYTES);
                end
                sat_hit = 1'b0;
            end
            SATURATING_ADD_HALFWORDS, SATURATING_SUBTRACT_HALFWORDS: begin
                for (int i = 0; i < 2; i++) begin
                    low_d[i*16 +: 16] = sat_half(REQ_I.first_operand[i*16 +: 16],
                                                 REQ_I.second_operand[i*16 +: 16],
                                                 REQ_I.op == SATURATING_SUBTRACT_HALFWORDS);
                end
                sat_hit = 1'b0;
            end
            // exchange forms cross the halves of the second operand
            SATURATING_ADD_SUBTRACT_EXCHANGE: begin
                low_d[31:16] = sat_half(REQ_I.first_operand[31:16],
                                        REQ_I.second_operand[15:0], 1'b0);
                low_d[15:0]  = sat_half(REQ_I.first_operand[15:0],
                                        REQ_I.second_operand[31:16], 1'b1);
            end
            SATURATING_SUBTRACT_ADD_EXCHANGE: begin
                low_d[31:16] = sat_half(REQ_I.first_operand[31:16],
                                        REQ_I.second_operand[15:0], 1'b1);
                low_d[15:0]  = sat_half(REQ_I.first_operand[15:0],
                                        REQ_I.second_operand[31:16], 1'b0);
            end
            // unused opcode values write nothing
            default: begin
                wr_low_d = 1'b0;
            end
        endcase
    end

    // result words and write strobes; no condition-flag port exists at all
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            res_valid_q <= 1'b0;
            wr_low_q    <= 1'b0;
            wr_high_q   <= 1'b0;
            res_low_q   <= RESULT_RESET;
            res_high_q  <= RESULT_RESET;
        end else if (CE_I) begin
            res_valid_q <= REQ_I.valid;
            // a failed condition suppresses both destination writes
            wr_low_q    <= REQ_I.valid && REQ_I.cond_pass && wr_low_d;
            wr_high_q   <= REQ_I.valid && REQ_I.cond_pass && wr_high_d;
            if (REQ_I.valid) begin
                res_low_q  <= low_d;
                res_high_q <= high_d;
            end
        end
    end

    // divide-by-zero trap pulse, only for a taken divide
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            div_fault_q <= 1'b0;
        end else if (CE_I) begin
            div_fault_q <= REQ_I.valid && REQ_I.cond_pass && div_fault_d;
        end
    end

    // sticky saturation flag: a clamp wins over a same-cycle status write
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            sat_flag_q <= SAT_FLAG_RESET;
        end else if (CE_I) begin
            if (REQ_I.valid && REQ_I.cond_pass && sat_hit) begin
                sat_flag_q <= 1'b1;
            end else if (STATUS_WR_I) begin
                sat_flag_q <= STATUS_WR_SAT_I;
            end
        end
    end

    // outputs straight from the registers
    assign RES_VALID_O = res_valid_q;
    assign WR_LOW_O    = wr_low_q;
    assign WR_HIGH_O   = wr_high_q;
    assign RES_LOW_O   = res_low_q;
    assign RES_HIGH_O  = res_high_q;
    assign SAT_FLAG_O  = sat_flag_q;
    assign DIV_FAULT_O = div_fault_q;

endmodule : long_mul_div_saturate_unit

/* File: verification/long_mul_div_saturate_unit_asserts.sv */
/* checker: timing and result relations at the unit's ports
   assumes: bound to the unit, one clock domain */
`timescale 1ns/1ps
module long_mul_div_saturate_unit_asserts
    import long_mul_div_saturate_pkg::*;
(
    // clock, reset and requests
    input wire logic CLK_I, NRST_I, CE_I, STATUS_WR_I, STATUS_WR_SAT_I, DIV_TRAP_EN_I,
    input wire long_mul_div_saturate_pkg::req_t REQ_I,
    // results and status
    input wire logic RES_VALID_O, WR_LOW_O, WR_HIGH_O, SAT_FLAG_O,
    input wire logic [31:0] RES_LOW_O, RES_HIGH_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);
    // request taken with its condition true
    wire logic go = CE_I && REQ_I.valid && REQ_I.cond_pass;
    // reference product and signed accumulate sum
    wire logic [63:0] pu = {32'h0, REQ_I.first_operand} * {32'h0, REQ_I.second_operand};
    wire logic signed [63:0] ps = $signed({REQ_I.acc_high, REQ_I.acc_low})
        + $signed(REQ_I.first_operand) * $signed(REQ_I.second_operand);
    a_answer_next: assert property (CE_I && REQ_I.valid |=> RES_VALID_O)
        else $error("answer missing");
    a_cond_fail: assert property (CE_I && REQ_I.valid && !REQ_I.cond_pass |=>
        !WR_LOW_O && !WR_HIGH_O) else $error("write on failed condition");
    a_umul_split: assert property (go && REQ_I.op == UNSIGNED_LONG_MULTIPLY |=>
        WR_HIGH_O && {RES_HIGH_O, RES_LOW_O} == $past(pu)) else $error("bad product");
    a_sacc_sum: assert property (go && REQ_I.op == SIGNED_LONG_MULTIPLY_ACCUMULATE |=>
        {RES_HIGH_O, RES_LOW_O} == $past(ps)) else $error("bad signed sum");
    a_div_zero: assert property (go && REQ_I.op == UNSIGNED_DIVIDE &&
        REQ_I.second_operand == 32'h0 && !DIV_TRAP_EN_I |=> WR_LOW_O && RES_LOW_O == 32'h0)
        else $error("zero divisor result");
    a_div_flag: assert property (CE_I && REQ_I.valid && !STATUS_WR_I &&
        REQ_I.op inside {SIGNED_DIVIDE, UNSIGNED_DIVIDE} |=> $stable(SAT_FLAG_O))
        else $error("divide moved flag");
    a_pack_flag: assert property (CE_I && REQ_I.valid && !STATUS_WR_I &&
        REQ_I.op inside {[SATURATING_ADD_BYTES:SATURATING_SUBTRACT_HALFWORDS]} |=>
        $stable(SAT_FLAG_O)) else $error("packed op moved flag");
    a_flag_sticky: assert property (SAT_FLAG_O && !(CE_I && STATUS_WR_I) |=> SAT_FLAG_O)
        else $error("flag lost");
    a_flag_clear: assert property (CE_I && STATUS_WR_I && !STATUS_WR_SAT_I &&
        !REQ_I.valid |=> !SAT_FLAG_O) else $error("flag not cleared");
endmodule : long_mul_div_saturate_unit_asserts

/* File: verification/reg_pair_model.sv */
/* destination register pair that receives the unit's results
   assumes: write strobes and words arrive on the core clock */
`timescale 1ns/1ps
module reg_pair_model (
    // clock, reset, write side
    input  wire logic        clk_i, nrst_i, wr_low_i, wr_high_i,
    input  wire logic [31:0] low_i, high_i,
    // stored pair
    output logic      [31:0] low_q_o, high_q_o
);
    // two separate registers, so both halves of a product survive
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            low_q_o  <= 32'h0;
            high_q_o <= 32'h0;
        end else begin
            if (wr_low_i) low_q_o <= low_i;
            if (wr_high_i) high_q_o <= high_i;
        end
    end
endmodule : reg_pair_model

/* File: verification/long_mul_div_saturate_unit_tb.sv */
/* random testbench for the multiply, divide and saturate unit
   assumes: one-edge answer, inputs changed on the falling edge */
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module long_mul_div_saturate_unit_tb;
    import long_mul_div_saturate_pkg::*;
    logic CLK_I = 0, NRST_I = 0, CE_I = 1, STATUS_WR_I = 0, STATUS_WR_SAT_I = 0;
    logic DIV_TRAP_EN_I = 0, RES_VALID_O, WR_LOW_O, WR_HIGH_O, SAT_FLAG_O, DIV_FAULT_O;
    req_t REQ_I = '0;
    logic [31:0] RES_LOW_O, RES_HIGH_O, mlo, mhi, qlo = 0, qhi = 0, seed = 32'hFC7AC50E;
    logic [31:0] cw [4] = '{32'h0, 32'hFFFFFFFF, 32'h80000000, 32'h7FFFFFFF};
    logic ev = 0, ew = 0, eh = 0, es = 0, ef = 0; // expected strobes and flag
    logic [64:0] er = '0; // expected flag-set bit and 64-bit result
    int failures = 0, n_compared = 0, cyc = 0;
    long_mul_div_saturate_unit dut (.*);
    reg_pair_model regs (.clk_i(CLK_I), .nrst_i(NRST_I), .wr_low_i(WR_LOW_O),
        .wr_high_i(WR_HIGH_O), .low_i(RES_LOW_O), .high_i(RES_HIGH_O), .low_q_o(mlo), .high_q_o(mhi));
    initial forever #5 CLK_I = ~CLK_I;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // signed lane i of width w
    function automatic longint lane(logic [31:0] d, int i, int w);
        return (longint'(d >> (i * w)) << (64 - w)) >>> (64 - w);
    endfunction : lane
    function automatic longint clamp(longint u, int n, bit s);
        longint hi = s ? (64'sd1 <<< (n - 1)) - 1 : (64'sd1 <<< n) - 1;
        longint lo = s ? -hi - 1 : 0;
        return u > hi ? hi : (u < lo ? lo : u);
    endfunction : clamp
    function automatic logic [64:0] exp_of(req_t r);
        logic [31:0] f = r.first_operand, s = r.second_operand;
        longint a = $signed(f), b = $signed(s), u, v;
        logic [63:0] acc = {r.acc_high, r.acc_low}, res = '0;
        bit sat = 0, sw = r.op inside {[SIGNED_SATURATE:UNSIGNED_SATURATE_HALFWORDS]};
        bit us = r.op inside {UNSIGNED_SATURATE, UNSIGNED_SATURATE_HALFWORDS};
        bit pk = r.op inside {[SATURATING_ADD_BYTES:SATURATING_SUBTRACT_ADD_EXCHANGE]};
        bit x = r.op inside {SATURATING_ADD_SUBTRACT_EXCHANGE, SATURATING_SUBTRACT_ADD_EXCHANGE};
        bit sub = r.op inside {SATURATING_SUBTRACT, SATURATING_SUBTRACT_BYTES,
            SATURATING_SUBTRACT_HALFWORDS};
        int w = r.op inside {SATURATING_ADD_BYTES, SATURATING_SUBTRACT_BYTES} ? 8 : (pk ||
            r.op inside {SIGNED_SATURATE_HALFWORDS, UNSIGNED_SATURATE_HALFWORDS}) ? 16 : 32;
        case (r.op)
            UNSIGNED_LONG_MULTIPLY: return {1'b0, 64'(f) * s};
            UNSIGNED_LONG_MULTIPLY_ACCUMULATE: return {1'b0, 64'(f) * s + acc};
            SIGNED_LONG_MULTIPLY: return {1'b0, 64'(a * b)};
            SIGNED_LONG_MULTIPLY_ACCUMULATE: return {1'b0, 64'(a * b) + acc};
            UNSIGNED_DIVIDE: return {33'h0, s == 0 ? 32'h0 : f / s};
            SIGNED_DIVIDE: return {33'h0, b == 0 ? 32'h0 : 32'(a / b)};
            default: begin
                for (int i = 0; i < 32 / w; i++) begin
                    u = lane(s, x ? 1 - i : i, w);
                    if (x) sub = i == (r.op == SATURATING_SUBTRACT_ADD_EXCHANGE);
                    if (!sw) u = lane(f, i, w) + (sub ? -u : u);
                    if (sw && w == 32) u = r.shift_right ? b >>> r.shift_amount
                        : lane(s << r.shift_amount, 0, 32);
                    v = clamp(u, sw ? r.sat_width : w, !us);
                    sat |= v != u;
                    res |= 64'(v & ((64'sd1 <<< w) - 1)) << (i * w);
                end
                return {sat && !pk, res};
            end
        endcase
    endfunction : exp_of
    // random request and its expected answer
    task automatic drive();
        logic [31:0] r = rnd();
        logic [31:0] n = rnd();
        CE_I = r[31:28] != 0;
        STATUS_WR_I = r[27:24] == 0;
        STATUS_WR_SAT_I = r[23];
        DIV_TRAP_EN_I = r[22:19] == 0;
        REQ_I.valid = r[18:16] != 0;
        REQ_I.cond_pass = r[15:13] != 0;
        REQ_I.op = op_t'(5'(n[31:20] % 18));
        REQ_I.first_operand = r[6] ? rnd() : cw[r[5:4]];
        REQ_I.second_operand = r[3] ? rnd() : cw[r[2:1]];
        {REQ_I.acc_high, REQ_I.acc_low} = {qhi, qlo};
        REQ_I.shift_right = n[8];
        REQ_I.shift_amount = n[8] ? 5'(1 + n[7:0] % 31) : n[4:0];
        REQ_I.sat_width = REQ_I.op == UNSIGNED_SATURATE ? n[4:0] : REQ_I.op ==
            UNSIGNED_SATURATE_HALFWORDS ? n[3:0] :
            6'(1 + n[19:12] % (REQ_I.op == SIGNED_SATURATE_HALFWORDS ? 16 : 32));
        if (CE_I) begin
            ef = REQ_I.valid && REQ_I.cond_pass && DIV_TRAP_EN_I && REQ_I.second_operand == 0
                && REQ_I.op inside {SIGNED_DIVIDE, UNSIGNED_DIVIDE};
            ev = REQ_I.valid;
            ew = REQ_I.valid && REQ_I.cond_pass && !ef;
            eh = ew && REQ_I.op <= SIGNED_LONG_MULTIPLY_ACCUMULATE;
            er = exp_of(REQ_I);
            es = (STATUS_WR_I ? STATUS_WR_SAT_I : es) | (ew && er[64]);
        end
    endtask : drive
    task automatic finish_test();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : finish_test
    // cycle ceiling against a hang
    always @(posedge CLK_I) if (++cyc > 4000) begin failures++; finish_test(); end
    initial begin
        repeat (8) @(negedge CLK_I);
        NRST_I = 1;
        repeat (3000) begin
            @(negedge CLK_I);
            `CHK(RES_VALID_O, ev)
            `CHK(WR_LOW_O, ew)
            `CHK(WR_HIGH_O, eh)
            `CHK(DIV_FAULT_O, ef)
            `CHK(SAT_FLAG_O, es)
            if (ev) `CHK(RES_LOW_O, er[31:0])
            if (ev) `CHK(RES_HIGH_O, er[63:32])
            `CHK({mhi, mlo}, {qhi, qlo})
            if (ew) qlo = er[31:0];
            if (eh) qhi = er[63:32];
            drive();
        end
        finish_test();
    end
endmodule : long_mul_div_saturate_unit_tb
bind long_mul_div_saturate_unit long_mul_div_saturate_unit_asserts chk (.*);
